//--- thermal_override_map.svh
`ifndef THERMAL_OVERRIDE_MAP_SVH
`define THERMAL_OVERRIDE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FAN_MIN_SPIN_CONTROL_ADDR     8'h62
`define REMOTE1_CRITICAL_LIMIT_ADDR   8'h6a
`define LOCAL_CRITICAL_LIMIT_ADDR     8'h6b
`define REMOTE2_CRITICAL_LIMIT_ADDR   8'h6c
`define REMOTE1_LOCAL_HYSTERESIS_ADDR 8'h6d
`define REMOTE2_HYSTERESIS_ADDR       8'h6e

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRITICAL_LIMIT_RST            8'ha4
`define HYSTERESIS_RST                4'h4
`define FAN_MIN_SPIN_CONTROL_RST      8'h00
`define UNMAPPED_READ_VALUE           8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FAN1_KEEP_SPINNING_BIT        5
`define FAN2_KEEP_SPINNING_BIT        6
`define FAN3_KEEP_SPINNING_BIT        7
`define HYST_HI_MSB                   7
`define HYST_HI_LSB                   4
`define HYST_LO_MSB                   3
`define HYST_LO_LSB                   0

// ----------------------------------------------------------------
// duty codes
// ----------------------------------------------------------------
`define FULL_DUTY                     8'hff
`define ZERO_DUTY                     8'h00

`endif

//--- thermal_override_pkg.sv
package thermal_override_pkg;

  typedef logic [7:0] temp_t;
  typedef logic [7:0] duty_t;
  typedef logic [3:0] hyst_t;

  typedef enum logic
  {
    st_normal   = 1'b0,
    st_override = 1'b1
  } override_state_e;

  typedef enum logic
  {
    fan_stopped = 1'b0,
    fan_running = 1'b1
  } fan_state_e;

endpackage : thermal_override_pkg

//--- channel_status_if.sv
`timescale 1ns/100ps

interface channel_status_if;

  thermal_override_pkg::temp_t temperature;
  thermal_override_pkg::temp_t critical_temp_limit;
  thermal_override_pkg::temp_t fan_start_temperature;
  thermal_override_pkg::hyst_t temperature_hysteresis;
  logic                        override_active;
  logic                        fan_on;
  logic                        below_start;

  modport monitor
  (
    input  temperature,
    input  critical_temp_limit,
    input  fan_start_temperature,
    input  temperature_hysteresis,
    output override_active,
    output fan_on,
    output below_start
  );

  modport control
  (
    output temperature,
    output critical_temp_limit,
    output fan_start_temperature,
    output temperature_hysteresis,
    input  override_active,
    input  fan_on,
    input  below_start
  );

endinterface : channel_status_if

//--- channel_hysteresis.sv
`timescale 1ns/100ps

module channel_hysteresis
(
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             clk_en,
  channel_status_if.monitor    chan
);

  thermal_override_pkg::override_state_e state_ff;
  thermal_override_pkg::override_state_e nxt_state;
  thermal_override_pkg::fan_state_e      fan_ff;
  thermal_override_pkg::fan_state_e      nxt_fan;
  logic                                  below_ff;
  logic [8:0]                            temp_plus_hyst;

  // adding to the temperature avoids underflow of limit minus hysteresis;
  // a zero hysteresis then releases just below the threshold
  assign temp_plus_hyst = {1'b0, chan.temperature} + {5'h00, chan.temperature_hysteresis};

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      thermal_override_pkg::st_normal:
        if (chan.temperature > chan.critical_temp_limit)
          nxt_state = thermal_override_pkg::st_override;
      thermal_override_pkg::st_override:
        if (temp_plus_hyst < {1'b0, chan.critical_temp_limit})
          nxt_state = thermal_override_pkg::st_normal;
    endcase
  end

  always_comb
  begin
    nxt_fan = fan_ff;
    unique case (fan_ff)
      thermal_override_pkg::fan_stopped:
        if (chan.temperature > chan.fan_start_temperature)
          nxt_fan = thermal_override_pkg::fan_running;
      thermal_override_pkg::fan_running:
        if (temp_plus_hyst < {1'b0, chan.fan_start_temperature})
          nxt_fan = thermal_override_pkg::fan_stopped;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= thermal_override_pkg::st_normal;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fan_ff <= thermal_override_pkg::fan_stopped;
    else if (clk_en)
      fan_ff <= nxt_fan;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      below_ff <= 1'b0;
    else if (clk_en)
      below_ff <= (chan.temperature < chan.fan_start_temperature);
  end

  assign chan.override_active = (state_ff == thermal_override_pkg::st_override);
  assign chan.fan_on          = (fan_ff == thermal_override_pkg::fan_running);
  assign chan.below_start     = below_ff;

endmodule : channel_hysteresis

//--- fan_duty_select.sv
`timescale 1ns/100ps
`include "thermal_override_map.svh"

module fan_duty_select
(
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        any_override,
  input  wire logic                        fan_on,
  input  wire logic                        below_start,
  input  wire logic                        keep_spinning,
  input  wire thermal_override_pkg::duty_t auto_duty,
  input  wire thermal_override_pkg::duty_t minimum_duty_cycle,
  output thermal_override_pkg::duty_t      duty_ff
);

  thermal_override_pkg::duty_t nxt_duty;

  always_comb
  begin
    if (any_override)
      nxt_duty = `FULL_DUTY;
    else if (keep_spinning && (below_start || !fan_on))
      nxt_duty = minimum_duty_cycle;
    else if (!fan_on)
      nxt_duty = `ZERO_DUTY;
    else
      nxt_duty = auto_duty;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      duty_ff <= `ZERO_DUTY;
    else if (clk_en)
      duty_ff <= nxt_duty;
  end

endmodule : fan_duty_select

//--- thermal_override_hysteresis.sv
// Overview of operation
// - any channel above its critical limit forces every fan to full duty.
// - full duty holds until that channel drops below limit minus hysteresis.
// - every hysteresis field resets to four degrees.
// - hysteresis is a four-bit field in one-degree steps, one to fifteen.
// - zero hysteresis means none; software should never program zero.
// - the critical override cannot be masked by any fan configuration.
// - three 8-bit critical limits, remote 1, local, remote 2, reset 100 degrees.
// - first hysteresis register: remote 1 upper nibble, local lower nibble.
// - second hysteresis register: remote 2 in upper nibble.
// - one hysteresis per channel serves override release and fan turn-off.
// - keep-spinning bit zero stops the fan below threshold minus hysteresis.
// - keep-spinning bit one holds minimum duty as soon as the channel drops below the threshold.
// - for a keep-spinning fan, hysteresis has no effect below the threshold.
`timescale 1ns/100ps
`include "thermal_override_map.svh"

module thermal_override_hysteresis
#(
  parameter int NUM_CHANNELS = 3
)
(
  input  wire logic                                           sys_clk,
  input  wire logic                                           rst_n,
  input  wire logic                                           clk_en,
  input  wire logic [7:0]                                     reg_addr,
  input  wire logic                                           reg_wr_en,
  input  wire logic [7:0]                                     reg_wdata,
  input  wire logic                                           reg_rd_en,
  input  wire thermal_override_pkg::temp_t [NUM_CHANNELS-1:0] temperature,
  input  wire thermal_override_pkg::temp_t [NUM_CHANNELS-1:0] fan_start_temperature,
  input  wire thermal_override_pkg::duty_t [NUM_CHANNELS-1:0] auto_duty,
  input  wire thermal_override_pkg::duty_t [NUM_CHANNELS-1:0] minimum_duty_cycle,
  output logic [7:0]                                          reg_rdata_ff,
  output logic                                                reg_rd_valid_ff,
  output thermal_override_pkg::duty_t [NUM_CHANNELS-1:0]      fan_duty,
  output logic                                                critical_thermal_ff,
  output logic [NUM_CHANNELS-1:0]                             channel_override
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]                                          fan_min_spin_control_ff;
  thermal_override_pkg::temp_t [NUM_CHANNELS-1:0]      critical_temp_limit_ff;
  thermal_override_pkg::hyst_t [NUM_CHANNELS-1:0]      temperature_hysteresis_ff;
  logic [NUM_CHANNELS-1:0]                             fan_keep_spinning;
  logic [NUM_CHANNELS-1:0]                             fan_on_vec;
  logic [NUM_CHANNELS-1:0]                             below_start_vec;
  logic                                                any_override;
  logic [7:0]                                          nxt_rdata;

  channel_status_if chan_bus [NUM_CHANNELS] ();

  // ----------------------------------------------------------------
  // keep-spinning bits
  // ----------------------------------------------------------------
  assign fan_keep_spinning[0] = fan_min_spin_control_ff[`FAN1_KEEP_SPINNING_BIT];
  assign fan_keep_spinning[1] = fan_min_spin_control_ff[`FAN2_KEEP_SPINNING_BIT];
  assign fan_keep_spinning[2] = fan_min_spin_control_ff[`FAN3_KEEP_SPINNING_BIT];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // low bits of the spin control register are stored and read back
  // so software sees exactly what it wrote
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fan_min_spin_control_ff <= `FAN_MIN_SPIN_CONTROL_RST;
    else if (clk_en && reg_wr_en && (reg_addr == `FAN_MIN_SPIN_CONTROL_ADDR))
      fan_min_spin_control_ff <= reg_wdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      critical_temp_limit_ff[0] <= `CRITICAL_LIMIT_RST;
      critical_temp_limit_ff[1] <= `CRITICAL_LIMIT_RST;
      critical_temp_limit_ff[2] <= `CRITICAL_LIMIT_RST;
    end
    else if (clk_en && reg_wr_en)
    begin
      unique case (reg_addr)
        `REMOTE1_CRITICAL_LIMIT_ADDR: critical_temp_limit_ff[0] <= reg_wdata;
        `LOCAL_CRITICAL_LIMIT_ADDR:   critical_temp_limit_ff[1] <= reg_wdata;
        `REMOTE2_CRITICAL_LIMIT_ADDR: critical_temp_limit_ff[2] <= reg_wdata;
        default:                      ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temperature_hysteresis_ff[0] <= `HYSTERESIS_RST;
      temperature_hysteresis_ff[1] <= `HYSTERESIS_RST;
      temperature_hysteresis_ff[2] <= `HYSTERESIS_RST;
    end
    else if (clk_en && reg_wr_en)
    begin
      // full four-bit nibble stored as written
      // zero is accepted and simply disables hysteresis
      // remote 1 high nibble, local low nibble
      if (reg_addr == `REMOTE1_LOCAL_HYSTERESIS_ADDR)
      begin
        temperature_hysteresis_ff[0] <= reg_wdata[`HYST_HI_MSB:`HYST_HI_LSB];
        temperature_hysteresis_ff[1] <= reg_wdata[`HYST_LO_MSB:`HYST_LO_LSB];
      end
      if (reg_addr == `REMOTE2_HYSTERESIS_ADDR)
        temperature_hysteresis_ff[2] <= reg_wdata[`HYST_HI_MSB:`HYST_HI_LSB];
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (reg_addr)
      `FAN_MIN_SPIN_CONTROL_ADDR:     nxt_rdata = fan_min_spin_control_ff;
      `REMOTE1_CRITICAL_LIMIT_ADDR:   nxt_rdata = critical_temp_limit_ff[0];
      `LOCAL_CRITICAL_LIMIT_ADDR:     nxt_rdata = critical_temp_limit_ff[1];
      `REMOTE2_CRITICAL_LIMIT_ADDR:   nxt_rdata = critical_temp_limit_ff[2];
      `REMOTE1_LOCAL_HYSTERESIS_ADDR: nxt_rdata = {temperature_hysteresis_ff[0], temperature_hysteresis_ff[1]};
      // unused low nibble reads zero
      `REMOTE2_HYSTERESIS_ADDR:       nxt_rdata = {temperature_hysteresis_ff[2], 4'h0};
      default:                        nxt_rdata = `UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= `UNMAPPED_READ_VALUE;
    else if (clk_en && reg_rd_en)
      reg_rdata_ff <= nxt_rdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rd_valid_ff <= 1'b0;
    else if (clk_en)
      reg_rd_valid_ff <= reg_rd_en;
  end

  // ----------------------------------------------------------------
  // per-channel hysteresis and per-fan duty
  // ----------------------------------------------------------------
  // fan n follows channel n; the channel-to-fan routing of the full
  // controller sits outside this block
  for (genvar g = 0; g < NUM_CHANNELS; g++)
  begin : g_chan
    assign chan_bus[g].temperature            = temperature[g];
    assign chan_bus[g].critical_temp_limit    = critical_temp_limit_ff[g];
    assign chan_bus[g].fan_start_temperature  = fan_start_temperature[g];
    // one hysteresis per channel, both uses
    assign chan_bus[g].temperature_hysteresis = temperature_hysteresis_ff[g];
    assign channel_override[g]                = chan_bus[g].override_active;
    assign fan_on_vec[g]                      = chan_bus[g].fan_on;
    assign below_start_vec[g]                 = chan_bus[g].below_start;

    channel_hysteresis u_channel_hysteresis
    (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .chan    (chan_bus[g])
    );

    fan_duty_select u_fan_duty_select
    (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .clk_en             (clk_en),
      .any_override       (any_override),
      .fan_on             (fan_on_vec[g]),
      .below_start        (below_start_vec[g]),
      .keep_spinning      (fan_keep_spinning[g]),
      .auto_duty          (auto_duty[g]),
      .minimum_duty_cycle (minimum_duty_cycle[g]),
      .duty_ff            (fan_duty[g])
    );
  end

  // ----------------------------------------------------------------
  // override combine
  // ----------------------------------------------------------------
  // any channel flag forces all fans
  assign any_override = |channel_override;

  // registered copy so the pin matches the fan duty timing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      critical_thermal_ff <= 1'b0;
    else if (clk_en)
      critical_thermal_ff <= any_override;
  end

endmodule : thermal_override_hysteresis

//--- thermal_override_hysteresis_monitor.sv
`timescale 1ns/100ps
module thermal_override_hysteresis_monitor
#(
  parameter int NUM_CHANNELS = 3
)
(
  input wire logic                                           sys_clk,
  input wire logic                                           rst_n,
  input wire logic                                           clk_en,
  input wire logic [7:0]                                     reg_addr,
  input wire logic                                           reg_wr_en,
  input wire logic [7:0]                                     reg_wdata,
  input wire logic                                           reg_rd_en,
  input wire thermal_override_pkg::temp_t [NUM_CHANNELS-1:0] temperature,
  input wire logic [7:0]                                     reg_rdata_ff,
  input wire logic                                           reg_rd_valid_ff,
  input wire thermal_override_pkg::duty_t [NUM_CHANNELS-1:0] fan_duty,
  input wire logic                                           critical_thermal_ff,
  input wire logic [NUM_CHANNELS-1:0]                        channel_override
);
  // ----------------------------------------------------------------
  // register mirror, rebuilt from observed writes
  // ----------------------------------------------------------------
  logic [7:0]              lim_ff [NUM_CHANNELS];
  logic [3:0]              hys_ff [NUM_CHANNELS];
  logic [7:0]              spin_ff;
  logic [NUM_CHANNELS-1:0] over;
  logic [NUM_CHANNELS-1:0] under;
  logic [7:0]              exp_rd;
  logic [NUM_CHANNELS-1:0] exp_ovr;
  logic                    all_full;

  // every fan at full duty at once
  assign all_full = (fan_duty == {NUM_CHANNELS{8'hff}});

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      lim_ff  <= '{default: 8'ha4};
      hys_ff  <= '{default: 4'h4};
      spin_ff <= 8'h00;
    end
    else if (clk_en && reg_wr_en)
      case (reg_addr)
        8'h62: spin_ff <= reg_wdata;
        8'h6a: lim_ff[0] <= reg_wdata;
        8'h6b: lim_ff[1] <= reg_wdata;
        8'h6c: lim_ff[2] <= reg_wdata;
        8'h6d:
        begin
          hys_ff[0] <= reg_wdata[7:4];
          hys_ff[1] <= reg_wdata[3:0];
        end
        8'h6e: hys_ff[2] <= reg_wdata[7:4];
        default: ;
      endcase

  // nine bits so temperature plus hysteresis never wraps
  always_comb
  begin
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      over[i]  = temperature[i] > lim_ff[i];
      under[i] = ({1'b0, temperature[i]} + {5'h00, hys_ff[i]}) < {1'b0, lim_ff[i]};
    end
    // a flag sets above the limit and clears only once under limit minus hysteresis
    exp_ovr = (channel_override | over) & ~under;
    case (reg_addr)
      8'h62: exp_rd = spin_ff;
      8'h6a: exp_rd = lim_ff[0];
      8'h6b: exp_rd = lim_ff[1];
      8'h6c: exp_rd = lim_ff[2];
      8'h6d: exp_rd = {hys_ff[0], hys_ff[1]};
      8'h6e: exp_rd = {hys_ff[2], 4'h0};
      default: exp_rd = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // set above limit, clear below limit minus hysteresis
  AST_OVR_NEXT: assert property (clk_en |=> channel_override == $past(exp_ovr))
    else $error("override flag update wrong");
  AST_FULL_DUTY: assert property (clk_en && |channel_override |=> all_full)
    else $error("fan duty not full under override");
  AST_CRIT: assert property (clk_en |=> critical_thermal_ff == |$past(channel_override))
    else $error("critical flag wrong");
  // hot channel reaches full duty in two cycles
  AST_PATH: assert property (clk_en && |over ##1 clk_en |=> critical_thermal_ff && all_full)
    else $error("hot channel did not force full duty");
  AST_RD_VALID: assert property (clk_en && reg_rd_en |=> reg_rd_valid_ff)
    else $error("read valid missing");
  AST_RD_IDLE: assert property (clk_en && !reg_rd_en |=> !reg_rd_valid_ff)
    else $error("read valid without read");
  // read data matches the register map
  AST_RD_DATA: assert property (clk_en && reg_rd_en |=> reg_rdata_ff == $past(exp_rd))
    else $error("read data wrong");
  // a frozen enable holds fan duties, override flags and read data
  AST_FREEZE: assert property (!clk_en |=> $stable({fan_duty, channel_override, reg_rdata_ff}))
    else $error("state moved while disabled");

  COV_RELEASE: cover property (|channel_override ##1 channel_override == '0);
  COV_MULTI: cover property ($countones(channel_override) > 1);
  COV_FROZEN: cover property (!clk_en && |channel_override);
endmodule : thermal_override_hysteresis_monitor

bind thermal_override_hysteresis thermal_override_hysteresis_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) u_monitor
(
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata),
  .reg_rd_en(reg_rd_en),
  .temperature(temperature),
  .reg_rdata_ff(reg_rdata_ff),
  .reg_rd_valid_ff(reg_rd_valid_ff),
  .fan_duty(fan_duty),
  .critical_thermal_ff(critical_thermal_ff),
  .channel_override(channel_override)
);

//--- fan_load.sv
`timescale 1ns/100ps
module fan_load
(
  input wire thermal_override_pkg::duty_t [2:0] duty,
  output logic [2:0]                            spinning
);
  // a fan turns only while its duty is nonzero
  always_comb
    for (int i = 0; i < 3; i++)
      spinning[i] = duty[i] != 8'h00;
endmodule : fan_load

//--- thermal_override_hysteresis_bench.sv
`timescale 1ns/100ps
module thermal_override_hysteresis_bench;
  logic                              sys_clk;
  logic                              rst_n;
  logic                              clk_en;
  logic [7:0]                        reg_addr;
  logic [7:0]                        reg_wdata;
  logic [7:0]                        reg_rdata_ff;
  logic                              reg_wr_en;
  logic                              reg_rd_en;
  logic                              reg_rd_valid_ff;
  logic                              critical_thermal_ff;
  logic [2:0]                        channel_override;
  logic [2:0]                        spinning;
  thermal_override_pkg::temp_t [2:0] temperature;
  thermal_override_pkg::temp_t [2:0] fan_start_temperature;
  thermal_override_pkg::duty_t [2:0] auto_duty;
  thermal_override_pkg::duty_t [2:0] minimum_duty_cycle;
  thermal_override_pkg::duty_t [2:0] fan_duty;
  int                                n_errors;
  int                                tests_run;
  logic [7:0]                        tab_a [7] = '{8'h62, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h63};
  logic [7:0]                        tab_r [7] = '{8'h00, 8'ha4, 8'ha4, 8'ha4, 8'h44, 8'h40, 8'h00};
  logic [7:0]                        tab_w [7] = '{8'h00, 8'h60, 8'h70, 8'h80, 8'h2f, 8'h5a, 8'h55};
  logic [7:0]                        tab_e [7] = '{8'h00, 8'h60, 8'h70, 8'h80, 8'h2f, 8'h50, 8'h00};

  thermal_override_hysteresis #(.NUM_CHANNELS(3)) DUT
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en),
    .temperature(temperature),
    .fan_start_temperature(fan_start_temperature),
    .auto_duty(auto_duty),
    .minimum_duty_cycle(minimum_duty_cycle),
    .reg_rdata_ff(reg_rdata_ff),
    .reg_rd_valid_ff(reg_rd_valid_ff),
    .fan_duty(fan_duty),
    .critical_thermal_ff(critical_thermal_ff),
    .channel_override(channel_override)
  );

  fan_load u_fans
  (
    .duty(fan_duty),
    .spinning(spinning)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic bad(input string m);
    n_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : bad

  task automatic chk_reg(input logic [7:0] e);
    tests_run++;
    if (reg_rd_valid_ff !== 1'b1 || reg_rdata_ff !== e)
      bad($sformatf("read %h expected %h", reg_rdata_ff, e));
  endtask : chk_reg

  task automatic chk_duty(input thermal_override_pkg::duty_t [2:0] e);
    tests_run++;
    if (fan_duty !== e || spinning !== {e[2] != 8'h00, e[1] != 8'h00, e[0] != 8'h00})
      bad($sformatf("duty %h expected %h", fan_duty, e));
  endtask : chk_duty

  task automatic chk_flag(input logic [3:0] e);
    tests_run++;
    if ({critical_thermal_ff, channel_override} !== e)
      bad($sformatf("flags %b expected %b", {critical_thermal_ff, channel_override}, e));
  endtask : chk_flag

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd_en = 1'b0;
    chk_reg(e);
  endtask : rd

  // override flags settle on the first edge, duties and the critical flag on the second
  task automatic step(input thermal_override_pkg::temp_t [2:0] t);
    @(posedge sys_clk);
    #1;
    temperature = t;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : step

  initial
  begin
    #100000;
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    temperature = {3{8'h20}};
    fan_start_temperature = {3{8'h30}};
    auto_duty = {8'h82, 8'h81, 8'h80};
    minimum_duty_cycle = {8'h22, 8'h21, 8'h20};
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk_flag(4'h0);
    chk_duty({3{8'h00}});
    foreach (tab_a[i])
      rd(tab_a[i], tab_r[i]);
    foreach (tab_a[i])
      wr(tab_a[i] == 8'h63 ? 8'h70 : tab_a[i], tab_w[i]);
    foreach (tab_a[i])
      rd(tab_a[i] == 8'h63 ? 8'h70 : tab_a[i], tab_e[i]);
    step({3{8'h31}});
    chk_duty({8'h82, 8'h81, 8'h80});
    step({3{8'h2e}});
    chk_duty({8'h82, 8'h81, 8'h80});
    step({3{8'h2d}});
    chk_duty({8'h82, 8'h81, 8'h00});
    wr(8'h62, 8'he0);
    step({3{8'h2d}});
    chk_duty({8'h22, 8'h21, 8'h20});
    wr(8'h62, 8'h40);
    step({3{8'h2d}});
    chk_duty({8'h82, 8'h21, 8'h00});
    step({8'h2d, 8'h71, 8'h2d});
    chk_flag(4'b1010);
    chk_duty({3{8'hff}});
    step({8'h2d, 8'h62, 8'h2d});
    chk_flag(4'b1010);
    step({8'h2d, 8'h60, 8'h2d});
    chk_flag(4'b0000);
    chk_duty({8'h82, 8'h81, 8'h00});
    wr(8'h6d, 8'h0f);
    step({8'h2d, 8'h60, 8'h61});
    chk_flag(4'b1001);
    step({8'h2d, 8'h60, 8'h60});
    chk_flag(4'b1001);
    step({8'h2d, 8'h60, 8'h5f});
    chk_flag(4'b0000);
    step({8'h81, 8'h60, 8'h61});
    chk_flag(4'b1101);
    step({8'h7a, 8'h60, 8'h61});
    chk_flag(4'b1001);
    chk_duty({3{8'hff}});
    @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    step({3{8'h2d}});
    chk_flag(4'b1001);
    wr(8'h6a, 8'h11);
    @(posedge sys_clk);
    #1;
    clk_en = 1'b1;
    rd(8'h6a, 8'h60);
    step({3{8'h2d}});
    chk_flag(4'b0000);
    end_of_test();
  end
endmodule : thermal_override_hysteresis_bench
